/* File: verilog/lalace_cfg.svh */
// lalace_cfg.svh: named constants of the low limit / command echo block
// assumes: included by bare name, before the package and the modules
`ifndef LALACE_CFG_SVH
`define LALACE_CFG_SVH

`define LALACE_NUM_CHAN      8
`define LALACE_ADDR_W        7
`define LALACE_CNT_W         6
`define LALACE_LOW_UP_BASE   7'h18
`define LALACE_LOW_LO_BASE   7'h19
`define LALACE_CHAN_STRIDE   7'h05
`define LALACE_ECHO_ADDR     7'h3F
`define LALACE_LAST_CMD_BIT  6'h0F
`define LALACE_CMD_BITS      6'h10
`define LALACE_ECHO_TOP      6'h17
`define LALACE_ECHO_END      6'h18
`define LALACE_FRAME_END     6'h20
`define LALACE_CNT_STEP      6'h01
`define LALACE_REG_RST       8'h00
`define LALACE_KEEP_RST      6'h00
`define LALACE_LOW_PAD       2'h0

`endif

/* File: verilog/lalace_pkg.sv */
// lalace_pkg: types shared by the low limit / command echo block
// assumes: lalace_cfg.svh on the include path
`include "lalace_cfg.svh"

package lalace_pkg;

  typedef logic [7:0]  lalace_byte_t;
  typedef logic [5:0]  lalace_keep_t;
  typedef logic [15:0] lalace_limit_t;

  // serial command word, msb first on the wire
  typedef struct packed {
    logic [`LALACE_ADDR_W-1:0] addr;
    logic                      wr;
    lalace_byte_t              data;
  } lalace_cmd_s;

endpackage : lalace_pkg

/* File: verilog/lalace_sync.sv */
// lalace_sync: two-flop level synchroniser into the system clock
// assumes: din is a level from another clock domain
`timescale 1ns/1ps

module lalace_sync #(
  parameter int W = 1
) (
  // system side
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= din;
      syncOut  <= stage1_r;
    end
  end

endmodule : lalace_sync

/* File: verilog/lalace_top.sv */
// lalace_top: low alarm limit registers and command echo behind a serial port
// assumes: host is serial master; frame select low during a frame; serialClk
// stands still outside frames; frames are at least 24 serial clocks long
`timescale 1ns/1ps
`include "lalace_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: per-channel read/write low limit upper byte, reset zero
// R2: channel 0 upper at 18h, lower 19h
// R3: lower byte bits 7..2 read/write, reset zero
// R4: lower byte bits 1..0 always read zero
// R5: limit is upper, six lower bits, two zeros
// R6: address 3Fh returns previous frame's command
// R7: echo shifted msb first from 16th falling edge
// R8: eight echo bits, then eight zero bits
// R9: host may stop after 24th serial clock
// R10: echo register holds previous command upper byte
// R11: writes to read-only bits are ignored
module lalace_top
  import lalace_pkg::*;
(
  // system clock and reset
  input  wire logic                             clock,
  input  wire logic                             sys_rst,
  // serial link
  input  wire logic                             serialClk,
  input  wire logic                             serialSelN,
  input  wire logic                             serialIn,
  output logic                                  serialOutLine,
  // effective limits and execution strobe
  output lalace_limit_t [`LALACE_NUM_CHAN-1:0]  chanLowLimit,
  output logic                                  cmdExecPulse
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [`LALACE_CNT_W-1:0]            bitCnt_r;
  logic [14:0]                         inShift_r;
  lalace_cmd_s                         cmdIn;
  lalace_cmd_s                         cmdHold_r;
  logic                                cmdValid_r;
  lalace_byte_t                        readByte_r;
  lalace_byte_t                        rdMux;
  logic                                lastCmdBit;
  logic [`LALACE_CNT_W-1:0]            echoIdx;
  logic                                validSync;
  logic                                validSeen_r;
  logic                                cmdEvt;
  lalace_byte_t [`LALACE_NUM_CHAN-1:0] limUpper_r;
  lalace_keep_t [`LALACE_NUM_CHAN-1:0] limLower_r;
  lalace_byte_t                        echo_r;

  function automatic logic [`LALACE_ADDR_W-1:0] chanAddr(
    input logic [`LALACE_ADDR_W-1:0] base,
    input int                        chan
  );
    chanAddr = 7'(int'(base) + int'(`LALACE_CHAN_STRIDE) * chan);
  endfunction : chanAddr

  //////////////////////////////////////////////////////////////////////////////
  // serial side: frame select high clears all frame state except the held word cmdHold_r

  assign cmdIn      = lalace_cmd_s'({inShift_r, serialIn});
  assign lastCmdBit = (bitCnt_r == `LALACE_LAST_CMD_BIT);
  assign echoIdx    = `LALACE_ECHO_TOP - bitCnt_r;

  // rising edges seen, saturating
  always_ff @(posedge serialClk or posedge serialSelN) begin
    if (serialSelN) begin
      bitCnt_r <= '0;
    end else if (bitCnt_r != `LALACE_FRAME_END) begin
      bitCnt_r <= bitCnt_r + `LALACE_CNT_STEP;
    end
  end

  always_ff @(posedge serialClk or posedge serialSelN) begin
    if (serialSelN) begin
      inShift_r <= '0;
    end else if (bitCnt_r < `LALACE_CMD_BITS) begin
      inShift_r <= {inShift_r[13:0], serialIn};
    end
  end

  // held word, stable until the next frame's 16th rising edge
  always_ff @(posedge serialClk) begin
    if (lastCmdBit && !serialSelN) begin
      cmdHold_r <= cmdIn;
    end
  end

  // level handshake: raised on capture, dropped by frame end
  always_ff @(posedge serialClk or posedge serialSelN) begin
    if (serialSelN) begin
      cmdValid_r <= 1'b0;
    end else if (lastCmdBit) begin
      cmdValid_r <= 1'b1;
    end
  end

  // register read mux; system-side registers are quasi-static here
  always_comb begin
    rdMux = `LALACE_REG_RST;
    if (cmdIn.addr == `LALACE_ECHO_ADDR) begin
      rdMux = echo_r; // R6
    end
    for (int n = 0; n < `LALACE_NUM_CHAN; n++) begin
      if (cmdIn.addr == chanAddr(`LALACE_LOW_UP_BASE, n)) begin
        rdMux = limUpper_r[n]; // R2
      end
      if (cmdIn.addr == chanAddr(`LALACE_LOW_LO_BASE, n)) begin
        rdMux = {limLower_r[n], `LALACE_LOW_PAD}; // R4
      end
    end
  end

  // sampled before the system side executes this frame's command
  always_ff @(posedge serialClk or posedge serialSelN) begin
    if (serialSelN) begin
      readByte_r <= `LALACE_REG_RST;
    end else if (lastCmdBit) begin
      readByte_r <= cmdIn.wr ? `LALACE_REG_RST : rdMux; // R6
    end
  end

  // data changes on falling edges, from the 16th onward
  always_ff @(negedge serialClk or posedge serialSelN) begin
    if (serialSelN) begin
      serialOutLine <= 1'b0;
    end else if (bitCnt_r >= `LALACE_CMD_BITS && bitCnt_r < `LALACE_ECHO_END) begin
      serialOutLine <= readByte_r[echoIdx[2:0]]; // R7
    end else begin
      serialOutLine <= 1'b0; // R8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crossing into the system clock

  lalace_sync #(
    .W (1)
  ) u_validSync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (cmdValid_r),
    .syncOut (validSync)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      validSeen_r <= 1'b0;
    end else begin
      validSeen_r <= validSync;
    end
  end

  assign cmdEvt = validSync && !validSeen_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmdExecPulse <= 1'b0;
    end else begin
      cmdExecPulse <= cmdEvt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      limUpper_r <= '0; // R1
      limLower_r <= '0; // R3
    end else if (cmdEvt && cmdHold_r.wr) begin
      for (int n = 0; n < `LALACE_NUM_CHAN; n++) begin
        if (cmdHold_r.addr == chanAddr(`LALACE_LOW_UP_BASE, n)) begin
          limUpper_r[n] <= cmdHold_r.data; // R1
        end
        if (cmdHold_r.addr == chanAddr(`LALACE_LOW_LO_BASE, n)) begin
          limLower_r[n] <= cmdHold_r.data[7:2]; // R3 R11
        end
      end
    end
  end

  // upper byte of every executed command; writes to 3Fh store nothing else
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      echo_r <= `LALACE_REG_RST; // R10
    end else if (cmdEvt) begin
      echo_r <= {cmdHold_r.addr, cmdHold_r.wr}; // R10
    end
  end

  always_comb begin
    for (int n = 0; n < `LALACE_NUM_CHAN; n++) begin
      chanLowLimit[n] = {limUpper_r[n], limLower_r[n], `LALACE_LOW_PAD}; // R5
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks, system clock

  sequence sWrUp0;
    cmdEvt && cmdHold_r.wr && cmdHold_r.addr == `LALACE_LOW_UP_BASE;
  endsequence

  sequence sWrLo0;
    cmdEvt && cmdHold_r.wr && cmdHold_r.addr == `LALACE_LOW_LO_BASE;
  endsequence

  AST_UPPER_RESET: assert property (@(posedge clock) // R1
    sys_rst |=> chanLowLimit[0][15:8] == `LALACE_REG_RST && chanLowLimit[7][15:8] == `LALACE_REG_RST)
    else $error("upper limit byte not zero after reset");

  AST_UPPER_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // R2
    sWrUp0 |=> cmdExecPulse && chanLowLimit[0][15:8] == $past(cmdHold_r.data))
    else $error("write to 18h did not reach channel 0 upper byte");

  AST_LOWER_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // R3
    sWrLo0 |=> chanLowLimit[0][7:2] == $past(cmdHold_r.data[7:2]))
    else $error("write to 19h did not reach channel 0 lower bits");

  AST_LOW_BITS_ZERO: assert property (@(posedge clock) disable iff (sys_rst) // R4
    sWrLo0 ##1 cmdExecPulse |-> chanLowLimit[0][1:0] == `LALACE_LOW_PAD)
    else $error("lower byte bits 1..0 not zero");

  AST_LIMIT_ORDER: assert property (@(posedge clock) disable iff (sys_rst) // R5
    sWrUp0 |=> chanLowLimit[0][7:0] == $past(chanLowLimit[0][7:0]))
    else $error("upper byte write disturbed the low part of the limit");

  AST_ECHO_UPDATE: assert property (@(posedge clock) disable iff (sys_rst) // R10
    cmdEvt |=> echo_r == $past(cmdHold_r[15:8]) ##1 !cmdExecPulse)
    else $error("echo register not loaded from executed command");

  AST_RO_IGNORED: assert property (@(posedge clock) disable iff (sys_rst) // R11
    cmdEvt && cmdHold_r.wr && cmdHold_r.addr == `LALACE_ECHO_ADDR |=> $stable(chanLowLimit))
    else $error("write to echo address changed a limit");

  //////////////////////////////////////////////////////////////////////////////
  // checks, serial clock

  sequence sEchoRead;
    lastCmdBit && !cmdIn.wr && cmdIn.addr == `LALACE_ECHO_ADDR;
  endsequence

  AST_ECHO_READ: assert property (@(posedge serialClk) disable iff (serialSelN) // R6
    sEchoRead |=> readByte_r == $past(echo_r))
    else $error("read-back did not sample the previous command");

  AST_SDO_FIRST: assert property (@(posedge serialClk) disable iff (serialSelN) // R7
    lastCmdBit |=> serialOutLine == readByte_r[7] ##1 serialOutLine == readByte_r[6])
    else $error("serial output not msb first from 16th falling edge");

  AST_SDO_TAIL: assert property (@(posedge serialClk) disable iff (serialSelN) // R8
    bitCnt_r >= `LALACE_ECHO_END && bitCnt_r < `LALACE_FRAME_END |-> !serialOutLine)
    else $error("serial output not zero after the eighth echo bit");

endmodule : lalace_top

/* File: dv/lalace_host_bfm.sv */
// lalace_host_bfm: serial bus master driving frames into lalace_top
// assumes: 30 ns serial clock, idle low between frames
`timescale 1ns/1ps

module lalace_host_bfm (
  // serial link toward the device
  output logic      serialClk,
  output logic      serialSelN,
  output logic      serialIn,
  input  wire logic serialOutLine
);
  // a clean rising select edge clears the device's link state at start
  initial begin
    serialClk = 1'b0;
    serialSelN = 1'b0;
    serialIn = 1'b0;
    #1 serialSelN = 1'b1;
  end

  ////////////////////////////////////////
  // one frame: 16 command bits msb first, then filler up to nClk clocks
  task automatic frame(input logic [15:0] cmd, input int nClk, output logic [7:0] rdByte,
                       output logic tailZero);
    rdByte = 8'h00;
    tailZero = 1'b1;
    #7.3 serialSelN = 1'b0;
    #15;
    for (int i = 1; i <= nClk; i++) begin
      serialIn = (i <= 16) ? cmd[16-i] : ~serialIn;
      #15 serialClk = 1'b1;
      if (i >= 17 && i <= 24) rdByte = {rdByte[6:0], serialOutLine};
      if (i > 24 && serialOutLine !== 1'b0) tailZero = 1'b0;
      #15 serialClk = 1'b0;
    end
    // frame may stop after the 24th clock
    #20 serialSelN = 1'b1;
    serialIn = ~serialIn;
    #25;
  endtask : frame
endmodule : lalace_host_bfm

/* File: dv/testbench.sv */
// testbench: self-checking bench for lalace_top through the host model
// assumes: lalace_cfg.svh on the include path, lalace_pkg compiled first
`timescale 1ns/1ps
`include "lalace_cfg.svh"

module testbench
  import lalace_pkg::*;
;
  logic clock, sys_rst, serialClk, serialSelN, serialIn, serialOutLine, cmdExecPulse;
  lalace_limit_t [`LALACE_NUM_CHAN-1:0] chanLowLimit;
  lalace_byte_t upRef [`LALACE_NUM_CHAN];
  lalace_byte_t loRef [`LALACE_NUM_CHAN];
  lalace_byte_t echoRef;
  logic [127:0] limQ [$];
  int n_fail, n_compared, cycles;

  lalace_top i_dut (.clock(clock), .sys_rst(sys_rst), .serialClk(serialClk), .serialSelN(serialSelN),
    .serialIn(serialIn), .serialOutLine(serialOutLine), .chanLowLimit(chanLowLimit),
    .cmdExecPulse(cmdExecPulse));
  lalace_host_bfm i_host (.serialClk(serialClk), .serialSelN(serialSelN), .serialIn(serialIn),
    .serialOutLine(serialOutLine));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  function automatic logic [6:0] upA(input int n);
    return `LALACE_LOW_UP_BASE + 7'(n) * `LALACE_CHAN_STRIDE;
  endfunction : upA

  function automatic logic [127:0] limits();
    logic [127:0] v;
    v = '0;
    for (int n = 0; n < `LALACE_NUM_CHAN; n++) v[n*16 +: 16] = {upRef[n], loRef[n][7:2], 2'h0};
    return v;
  endfunction : limits

  function automatic lalace_byte_t readRef(input logic [6:0] a);
    readRef = (a == `LALACE_ECHO_ADDR) ? echoRef : 8'h00;
    for (int n = 0; n < `LALACE_NUM_CHAN; n++) begin
      if (a == upA(n)) readRef = upRef[n];
      if (a == upA(n) + 7'h01) readRef = {loRef[n][7:2], 2'h0};
    end
  endfunction : readRef

  // one frame; notes expected limits for the exec monitor
  task automatic xfer(input logic [6:0] a, input logic wr, input lalace_byte_t d, input int nClk);
    logic [7:0] rd;
    logic tz;
    lalace_byte_t exp;
    exp = wr ? 8'h00 : readRef(a);
    if (nClk >= 16) begin
      for (int n = 0; n < `LALACE_NUM_CHAN && wr; n++) begin
        if (a == upA(n)) upRef[n] = d;
        if (a == upA(n) + 7'h01) loRef[n] = {d[7:2], 2'h0};
      end
      echoRef = {a, wr};
      limQ.push_back(limits());
    end
    @(posedge clock);
    #1;
    i_host.frame({a, wr, d}, nClk, rd, tz);
    if (nClk >= 24) check("read byte", rd, exp);
    if (nClk > 24) check("tail bits", tz, 1'b1);
  endtask : xfer

  task automatic clearRef();
    foreach (upRef[n]) upRef[n] = 8'h00;
    foreach (loRef[n]) loRef[n] = 8'h00;
    echoRef = 8'h00;
  endtask : clearRef

  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
    if (cmdExecPulse === 1'b1) begin
      if (limQ.size() == 0) check("unexpected exec", 1'b1, 1'b0);
      else check("low limits", chanLowLimit, limQ.pop_front());
    end
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    sys_rst = 1'b1;
    clearRef();
    void'($urandom(74040));
    repeat (16) @(posedge clock);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    xfer(upA(0), 1'b0, 8'h00, 24);
    xfer(upA(0) + 7'h01, 1'b0, 8'h00, 24);
    xfer(`LALACE_ECHO_ADDR, 1'b0, 8'h00, 32);
    for (int n = 0; n < `LALACE_NUM_CHAN; n++) begin
      xfer(upA(n), 1'b1, 8'($urandom), 24);
      xfer(upA(n) + 7'h01, 1'b1, 8'($urandom), 32);
    end
    for (int n = 0; n < `LALACE_NUM_CHAN; n++) begin
      xfer(upA(n), 1'b0, 8'($urandom), 24);
      xfer(upA(n) + 7'h01, 1'b0, 8'($urandom), 24);
    end
    xfer(`LALACE_ECHO_ADDR, 1'b1, 8'hFF, 24);
    xfer(7'h1A, 1'b1, 8'($urandom), 24);
    xfer(7'h70, 1'b1, 8'($urandom), 32);
    xfer(7'h70, 1'b0, 8'h00, 24);
    xfer(upA(3), 1'b1, 8'h5A, 12);
    xfer(`LALACE_ECHO_ADDR, 1'b0, 8'h00, 32);
    xfer(upA(3), 1'b0, 8'h00, 24);
    @(posedge clock);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 sys_rst = 1'b0;
    clearRef();
    check("reset limits", chanLowLimit, '0);
    xfer(`LALACE_ECHO_ADDR, 1'b0, 8'h00, 24);
    xfer(upA(7) + 7'h01, 1'b0, 8'h00, 24);
    repeat (10) @(posedge clock);
    check("pending notes", limQ.size(), 0);
    test_done();
  end
endmodule : testbench
